// File: verilog/scd_map.vh
`ifndef SCD_MAP_VH
`define SCD_MAP_VH

// Voltages are carried in units of 0.125 mV, so 12.375 mV is exactly 99 units.
`define SCD_LSB_UV 125
`define SCD_LOW_RANGE_MAX 16'h4e20

// Limit levels in per-mille of the set point, in output order.
`define SCD_PM_OV_FAULT 11'd1100
`define SCD_PM_OV_WARN 11'd1075
`define SCD_PM_CEILING 11'd1075
`define SCD_PM_UP_MARGIN 11'd1050
`define SCD_PM_PG_ON 11'd930
`define SCD_PM_PG_OFF 11'd920
`define SCD_PM_LO_MARGIN 11'd950
`define SCD_PM_UV_WARN 11'd935
`define SCD_PM_UV_FAULT 11'd930
`define SCD_PM_DIV 11'd1000
`define SCD_NUM_LIM 9

// Table selectors of the decode memory.
`define SCD_SEL_VOUT 2'd0
`define SCD_SEL_TRIM 2'd1
`define SCD_SEL_HV 2'd2
`define SCD_SEL_FREQ 2'd3

// Output-level strap level that defers to the high-voltage trim column.
`define SCD_VOUT_DEFER_LVL 4'h0

// Frequency table word layout.
`define SCD_FRQ_KHZ_MSB 15
`define SCD_FRQ_KHZ_LSB 6
`define SCD_PH_0 2'd0
`define SCD_PH_120 2'd1
`define SCD_PH_180 2'd2

// Address settings.
`define SCD_DEV_ADDR_RST 8'h4f
`define SCD_DEV_ADDR_RST_HI 3'h4
`define SCD_GRP_ADDR_RST 8'h80
`define SCD_ADDR_DIS_BIT 7
`define SCD_GLOBAL_A 7'h5a
`define SCD_GLOBAL_B 7'h5b

`endif

// File: verilog/scd_strap_rom.v
`timescale 1ns/1ns
`include "scd_map.vh"

module scd_strap_rom (
  input wire sys_clk,
  input wire rst,
  input wire [1:0] sel,
  input wire [3:0] level,
  output reg [15:0] data_q
);

  reg [15:0] data_d;

  always @*
  begin
    data_d = 16'h0000;
    case ({sel, level})
      // Base set point, level 0 defers to the trim strap.
      {`SCD_SEL_VOUT, 4'h0}: data_d = 16'h0000;
      {`SCD_SEL_VOUT, 4'h1}: data_d = 16'h6720;
      {`SCD_SEL_VOUT, 4'h2}: data_d = 16'h60e0;
      {`SCD_SEL_VOUT, 4'h3}: data_d = 16'h5aa0;
      {`SCD_SEL_VOUT, 4'h4}: data_d = 16'h5460;
      {`SCD_SEL_VOUT, 4'h5}: data_d = 16'h4e20;
      {`SCD_SEL_VOUT, 4'h6}: data_d = 16'h47e0;
      {`SCD_SEL_VOUT, 4'h7}: data_d = 16'h41a0;
      {`SCD_SEL_VOUT, 4'h8}: data_d = 16'h3b60;
      {`SCD_SEL_VOUT, 4'h9}: data_d = 16'h3520;
      {`SCD_SEL_VOUT, 4'ha}: data_d = 16'h2ee0;
      {`SCD_SEL_VOUT, 4'hb}: data_d = 16'h28a0;
      {`SCD_SEL_VOUT, 4'hc}: data_d = 16'h2260;
      {`SCD_SEL_VOUT, 4'hd}: data_d = 16'h1c20;
      {`SCD_SEL_VOUT, 4'he}: data_d = 16'h15e0;
      {`SCD_SEL_VOUT, 4'hf}: data_d = 16'h0fa0;
      // Signed trim offset.
      {`SCD_SEL_TRIM, 4'h0}: data_d = 16'h0318;
      {`SCD_SEL_TRIM, 4'h1}: data_d = 16'h02b5;
      {`SCD_SEL_TRIM, 4'h2}: data_d = 16'h0252;
      {`SCD_SEL_TRIM, 4'h3}: data_d = 16'h01ef;
      {`SCD_SEL_TRIM, 4'h4}: data_d = 16'h018c;
      {`SCD_SEL_TRIM, 4'h5}: data_d = 16'h0129;
      {`SCD_SEL_TRIM, 4'h6}: data_d = 16'h00c6;
      {`SCD_SEL_TRIM, 4'h7}: data_d = 16'h0063;
      {`SCD_SEL_TRIM, 4'h8}: data_d = 16'hff9d;
      {`SCD_SEL_TRIM, 4'h9}: data_d = 16'hff3a;
      {`SCD_SEL_TRIM, 4'ha}: data_d = 16'hfed7;
      {`SCD_SEL_TRIM, 4'hb}: data_d = 16'hfe74;
      {`SCD_SEL_TRIM, 4'hc}: data_d = 16'hfe11;
      {`SCD_SEL_TRIM, 4'hd}: data_d = 16'hfdae;
      {`SCD_SEL_TRIM, 4'he}: data_d = 16'hfd4b;
      {`SCD_SEL_TRIM, 4'hf}: data_d = 16'hfce8;
      // High-voltage column; levels below 6 clamp to the top value.
      {`SCD_SEL_HV, 4'h6}: data_d = 16'ha410;
      {`SCD_SEL_HV, 4'h7}: data_d = 16'h9c40;
      {`SCD_SEL_HV, 4'h8}: data_d = 16'h9470;
      {`SCD_SEL_HV, 4'h9}: data_d = 16'h8ca0;
      {`SCD_SEL_HV, 4'ha}: data_d = 16'h84d0;
      {`SCD_SEL_HV, 4'hb}: data_d = 16'h7d00;
      {`SCD_SEL_HV, 4'hc}: data_d = 16'h7530;
      {`SCD_SEL_HV, 4'hd}: data_d = 16'h7170;
      {`SCD_SEL_HV, 4'he}: data_d = 16'h6d60;
      {`SCD_SEL_HV, 4'hf}: data_d = 16'h6c20;
      // Linked frequency and phase; zero kHz means external clock.
      {`SCD_SEL_FREQ, 4'h0}: data_d = {16'h3e80 | {14'h0000, `SCD_PH_0}};
      {`SCD_SEL_FREQ, 4'h1}: data_d = {16'h3e80 | {14'h0000, `SCD_PH_120}};
      {`SCD_SEL_FREQ, 4'h2}: data_d = {16'h3e80 | {14'h0000, `SCD_PH_180}};
      {`SCD_SEL_FREQ, 4'h3}: data_d = {16'h6a40 | {14'h0000, `SCD_PH_0}};
      {`SCD_SEL_FREQ, 4'h4}: data_d = {16'h6a40 | {14'h0000, `SCD_PH_120}};
      {`SCD_SEL_FREQ, 4'h5}: data_d = {16'h6a40 | {14'h0000, `SCD_PH_180}};
      {`SCD_SEL_FREQ, 4'h6}: data_d = {16'h7d00 | {14'h0000, `SCD_PH_0}};
      {`SCD_SEL_FREQ, 4'h7}: data_d = {16'h7d00 | {14'h0000, `SCD_PH_0}};
      {`SCD_SEL_FREQ, 4'h8}: data_d = {16'h7d00 | {14'h0000, `SCD_PH_180}};
      {`SCD_SEL_FREQ, 4'h9}: data_d = {16'h8fc0 | {14'h0000, `SCD_PH_0}};
      {`SCD_SEL_FREQ, 4'ha}: data_d = {16'h8fc0 | {14'h0000, `SCD_PH_120}};
      {`SCD_SEL_FREQ, 4'hb}: data_d = {16'h8fc0 | {14'h0000, `SCD_PH_180}};
      {`SCD_SEL_FREQ, 4'hc}: data_d = {16'ha280 | {14'h0000, `SCD_PH_0}};
      {`SCD_SEL_FREQ, 4'hd}: data_d = {16'ha280 | {14'h0000, `SCD_PH_120}};
      {`SCD_SEL_FREQ, 4'he}: data_d = {16'ha280 | {14'h0000, `SCD_PH_180}};
      {`SCD_SEL_FREQ, 4'hf}: data_d = {14'h0000, `SCD_PH_0};
      default:
      begin
        if (sel == `SCD_SEL_HV)
          data_d = 16'habe0;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      data_q <= 16'h0000;
    else
      data_q <= data_d;
  end

endmodule

// File: verilog/scd_strap_decoder.v
// Summary of operation
// - Straps are captured once after reset release; later level changes are ignored.
// - Strapped set point derives all nine limit levels by fixed percentages.
// - Strapped set point at or below 2.5 V selects low range, else high.
// - Output-level strap gives 3.3 V down to 0.5 V; open keeps stored.
// - Trim strap adds +99 mV to -99 mV in 12.375 mV steps, skipping zero between levels 7 and 8; open adds zero.
// - Deferring output level takes set point from trim high-voltage column; with trim open the set point is zero.
// - Clock strap gives 250 to 650 kHz with 0/120/180 degrees (0/180 only at 500 kHz), or external.
// - Strapped frequency and phase load as one pair; bus settings independent.
// - Phase offsets are measured from the falling edge of the sync line.
// - 350, 750 and 1000 kHz come only from stored settings.
// - Device address is stored top three bits plus four strap bits.
// - Address levels map to nibbles F down to 0; open keeps stored address.
// - Stored device address defaults to 0x4F when never reprogrammed.
// - Global addresses 0x5A and 0x5B are always answered once configuration is done.
// - Writing 0x80 disables only that address setting.
// - A disabled setting does not stop matches on the other settings.
// - Settings hold 7-bit addresses right-justified; bus form is shifted left.
// - A floating output-level, clock or address strap keeps the stored parameters.
`timescale 1ns/1ns
`include "scd_map.vh"

module scd_strap_decoder (
  input wire sys_clk,
  input wire rst,
  input wire [3:0] out_level_strap_lvl,
  input wire out_level_strap_open,
  input wire [3:0] out_trim_strap_lvl,
  input wire out_trim_strap_open,
  input wire [3:0] clock_phase_strap_lvl,
  input wire clock_phase_strap_open,
  input wire [3:0] address_strap_lvl,
  input wire address_strap_open,
  input wire [15:0] nvm_setpoint,
  input wire nvm_range_high,
  input wire [15:0] nvm_ov_fault,
  input wire [15:0] nvm_ov_warn,
  input wire [15:0] nvm_ceiling,
  input wire [15:0] nvm_up_margin,
  input wire [15:0] nvm_pg_on,
  input wire [15:0] nvm_pg_off,
  input wire [15:0] nvm_lo_margin,
  input wire [15:0] nvm_uv_warn,
  input wire [15:0] nvm_uv_fault,
  input wire [9:0] nvm_freq_khz,
  input wire [8:0] nvm_phase_deg,
  input wire nvm_addr_programmed,
  input wire [7:0] nvm_dev_addr,
  input wire [7:0] nvm_group_addr,
  input wire addr_wr_en,
  input wire addr_wr_group,
  input wire [7:0] addr_wr_data,
  input wire [6:0] bus_addr,
  output reg [15:0] setpoint_q,
  output reg range_high_q,
  output wire [15:0] over_voltage_fault_level,
  output wire [15:0] over_voltage_warn_level,
  output wire [15:0] output_ceiling,
  output wire [15:0] upper_margin_level,
  output wire [15:0] pgood_on_level,
  output wire [15:0] pgood_off_level,
  output wire [15:0] lower_margin_level,
  output wire [15:0] under_voltage_warn_level,
  output wire [15:0] under_voltage_fault_level,
  output reg [9:0] freq_khz_q,
  output reg [8:0] phase_deg_q,
  output reg sync_drive_en_q,
  output reg [7:0] device_address_setting_q,
  output reg [7:0] group_address_setting_q,
  output wire [7:0] device_address_bus8,
  output wire addr_match,
  output reg cfg_done_q
);

  localparam [2:0] S_CAPT = 3'd0;
  localparam [2:0] S_READ = 3'd1;
  localparam [2:0] S_CALC = 3'd2;
  localparam [2:0] S_LIM = 3'd3;
  localparam [2:0] S_DONE = 3'd4;

  reg [2:0] state_q;
  reg [2:0] rd_idx_q;
  reg [3:0] lvl_q [0:3];
  reg [3:0] open_q;
  reg [15:0] base_q;
  reg [15:0] trim_q;
  reg [15:0] hv_q;
  reg [15:0] frq_q;
  reg sp_strapped_q;
  reg [15:0] lim_q [0:`SCD_NUM_LIM-1];
  reg [1:0] rom_sel;
  wire [15:0] rom_q;
  wire [15:0] nvm_lim [0:`SCD_NUM_LIM-1];
  wire [10:0] pm [0:`SCD_NUM_LIM-1];
  reg [15:0] sp_d;
  reg [8:0] ph_d;
  wire [9:0] frq_khz;
  wire dev_hit;
  wire grp_hit;
  wire glb_hit;
  integer k;

  assign nvm_lim[0] = nvm_ov_fault;
  assign nvm_lim[1] = nvm_ov_warn;
  assign nvm_lim[2] = nvm_ceiling;
  assign nvm_lim[3] = nvm_up_margin;
  assign nvm_lim[4] = nvm_pg_on;
  assign nvm_lim[5] = nvm_pg_off;
  assign nvm_lim[6] = nvm_lo_margin;
  assign nvm_lim[7] = nvm_uv_warn;
  assign nvm_lim[8] = nvm_uv_fault;

  assign pm[0] = `SCD_PM_OV_FAULT;
  assign pm[1] = `SCD_PM_OV_WARN;
  assign pm[2] = `SCD_PM_CEILING;
  assign pm[3] = `SCD_PM_UP_MARGIN;
  assign pm[4] = `SCD_PM_PG_ON;
  assign pm[5] = `SCD_PM_PG_OFF;
  assign pm[6] = `SCD_PM_LO_MARGIN;
  assign pm[7] = `SCD_PM_UV_WARN;
  assign pm[8] = `SCD_PM_UV_FAULT;

  assign over_voltage_fault_level = lim_q[0];
  assign over_voltage_warn_level = lim_q[1];
  assign output_ceiling = lim_q[2];
  assign upper_margin_level = lim_q[3];
  assign pgood_on_level = lim_q[4];
  assign pgood_off_level = lim_q[5];
  assign lower_margin_level = lim_q[6];
  assign under_voltage_warn_level = lim_q[7];
  assign under_voltage_fault_level = lim_q[8];

  // The decode tables are read one per cycle; data returns a cycle later.
  always @*
  begin
    rom_sel = rd_idx_q[1:0];
  end

  scd_strap_rom u_rom (
    .sys_clk(sys_clk),
    .rst(rst),
    .sel(rom_sel),
    .level(lvl_q[rom_sel]),
    .data_q(rom_q)
  );

  // Sequencer: capture, read four tables, form set point, form limits.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_CAPT;
      rd_idx_q <= 3'd0;
      cfg_done_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_CAPT:
        begin
          state_q <= S_READ;
          rd_idx_q <= 3'd0;
        end
        S_READ:
        begin
          rd_idx_q <= rd_idx_q + 3'd1;
          if (rd_idx_q == 3'd4)
            state_q <= S_CALC;
        end
        S_CALC:
          state_q <= S_LIM;
        S_LIM:
        begin
          state_q <= S_DONE;
          cfg_done_q <= 1'b1;
        end
        S_DONE:
          state_q <= S_DONE;
        default:
          state_q <= S_CAPT;
      endcase
    end
  end

  // Output, trim and clock strap levels are taken exactly once, in the first cycle after reset.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      open_q <= 4'hf;
      for (k = 0; k < 4; k = k + 1)
        lvl_q[k] <= 4'h0;
    end
    else if (state_q == S_CAPT)
    begin
      lvl_q[`SCD_SEL_VOUT] <= out_level_strap_lvl;
      lvl_q[`SCD_SEL_TRIM] <= out_trim_strap_lvl;
      lvl_q[`SCD_SEL_HV] <= out_trim_strap_lvl;
      lvl_q[`SCD_SEL_FREQ] <= clock_phase_strap_lvl;
      open_q <= {clock_phase_strap_open, out_trim_strap_open,
                 out_trim_strap_open, out_level_strap_open};
    end
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      base_q <= 16'h0000;
      trim_q <= 16'h0000;
      hv_q <= 16'h0000;
      frq_q <= 16'h0000;
    end
    else if (state_q == S_READ)
    begin
      case (rd_idx_q)
        3'd1: base_q <= rom_q;
        3'd2: trim_q <= rom_q;
        3'd3: hv_q <= rom_q;
        3'd4: frq_q <= rom_q;
        default: base_q <= base_q;
      endcase
    end
  end

  // Set point selection; an open trim strap contributes zero offset.
  always @*
  begin
    sp_d = nvm_setpoint;
    if (!open_q[`SCD_SEL_VOUT])
    begin
      if (lvl_q[`SCD_SEL_VOUT] == `SCD_VOUT_DEFER_LVL && !open_q[`SCD_SEL_HV])
        sp_d = hv_q;
      else if (open_q[`SCD_SEL_TRIM])
        sp_d = base_q;
      else
        sp_d = base_q + trim_q;
    end
  end

  assign frq_khz = frq_q[`SCD_FRQ_KHZ_MSB:`SCD_FRQ_KHZ_LSB];

  // Phase is counted from the falling edge of the shared sync line.
  always @*
  begin
    case (frq_q[1:0])
      `SCD_PH_120: ph_d = 9'd120;
      `SCD_PH_180: ph_d = 9'd180;
      default: ph_d = 9'd0;
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      setpoint_q <= 16'h0000;
      range_high_q <= 1'b0;
      sp_strapped_q <= 1'b0;
      freq_khz_q <= 10'h000;
      phase_deg_q <= 9'h000;
      sync_drive_en_q <= 1'b0;
    end
    else if (state_q == S_CALC)
    begin
      setpoint_q <= sp_d;
      sp_strapped_q <= !open_q[`SCD_SEL_VOUT];
      if (open_q[`SCD_SEL_VOUT])
        range_high_q <= nvm_range_high;
      else
        range_high_q <= (sp_d > `SCD_LOW_RANGE_MAX);
      if (open_q[`SCD_SEL_FREQ])
      begin
        freq_khz_q <= nvm_freq_khz;
        phase_deg_q <= nvm_phase_deg;
        sync_drive_en_q <= (nvm_freq_khz != 10'h000);
      end
      else
      begin
        freq_khz_q <= frq_khz;
        phase_deg_q <= ph_d;
        sync_drive_en_q <= (frq_khz != 10'h000);
      end
    end
  end

  // One divider per limit level, fed from the registered set point.
  genvar gi;
  generate
    for (gi = 0; gi < `SCD_NUM_LIM; gi = gi + 1)
    begin : g_lim
      wire [26:0] prod;
      wire [26:0] quot;
      assign prod = setpoint_q * pm[gi];
      assign quot = prod / {16'h0000, `SCD_PM_DIV};
      always @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          lim_q[gi] <= 16'h0000;
        else if (state_q == S_LIM)
        begin
          if (sp_strapped_q)
            lim_q[gi] <= quot[15:0];
          else
            lim_q[gi] <= nvm_lim[gi];
        end
      end
    end
  endgenerate

  // Address settings: loaded once from stored values and straps, then
  // written by the host; writes before configuration completes are ignored.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      device_address_setting_q <= `SCD_DEV_ADDR_RST;
      group_address_setting_q <= `SCD_GRP_ADDR_RST;
    end
    else if (state_q == S_CALC)
    begin
      if (nvm_addr_programmed)
        group_address_setting_q <= nvm_group_addr;
      if (!address_strap_open)
      begin
        if (nvm_addr_programmed)
          device_address_setting_q <= {1'b0, nvm_dev_addr[6:4],
                                       ~address_strap_lvl};
        else
          device_address_setting_q <= {1'b0, `SCD_DEV_ADDR_RST_HI,
                                       ~address_strap_lvl};
      end
      else if (nvm_addr_programmed)
        device_address_setting_q <= nvm_dev_addr;
    end
    else if (cfg_done_q && addr_wr_en)
    begin
      if (addr_wr_group)
        group_address_setting_q <= addr_wr_data;
      else
        device_address_setting_q <= addr_wr_data;
    end
  end

  assign device_address_bus8 = {device_address_setting_q[6:0], 1'b0};

  assign dev_hit = !device_address_setting_q[`SCD_ADDR_DIS_BIT] &&
                   (bus_addr == device_address_setting_q[6:0]);
  assign grp_hit = !group_address_setting_q[`SCD_ADDR_DIS_BIT] &&
                   (bus_addr == group_address_setting_q[6:0]);
  assign glb_hit = (bus_addr == `SCD_GLOBAL_A) ||
                   (bus_addr == `SCD_GLOBAL_B);
  assign addr_match = cfg_done_q && (dev_hit || grp_hit || glb_hit);

endmodule

// File: test/scd_strap_decoder_props.sv
`timescale 1ns/1ns
module scd_strap_props (
  input wire sys_clk,
  input wire rst,
  input wire out_level_strap_open,
  input wire clock_phase_strap_open,
  input wire addr_wr_en,
  input wire addr_wr_group,
  input wire [7:0] addr_wr_data,
  input wire [6:0] bus_addr,
  input wire [15:0] setpoint_q,
  input wire range_high_q,
  input wire [15:0] over_voltage_fault_level,
  input wire [9:0] freq_khz_q,
  input wire [8:0] phase_deg_q,
  input wire sync_drive_en_q,
  input wire [7:0] device_address_setting_q,
  input wire [7:0] group_address_setting_q,
  input wire [7:0] device_address_bus8,
  input wire addr_match,
  input wire cfg_done_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire strapped = cfg_done_q && !out_level_strap_open;
  done_rise_a:
    assert property ($fell(rst) |-> !cfg_done_q ##[6:12] cfg_done_q) else $error("no done");
  captured_a:
    assert property (cfg_done_q |=> $stable({setpoint_q, freq_khz_q, phase_deg_q}))
    else $error("decode moved");
  ov_fault_a:
    assert property (strapped |->
      over_voltage_fault_level == 16'(({16'h0000, setpoint_q} * 32'h44c) / 32'h3e8))
    else $error("bad fault level");
  range_sel_a:
    assert property (strapped |-> range_high_q == (setpoint_q > 16'h4e20)) else $error("range");
  freq_set_a:
    assert property (cfg_done_q && !clock_phase_strap_open |->
      freq_khz_q inside {10'h000, 10'h0fa, 10'h1a9, 10'h1f4, 10'h23f, 10'h28a})
    else $error("bad strap frequency");
  sync_drive_a:
    assert property (cfg_done_q |-> sync_drive_en_q == (freq_khz_q != 10'h000))
    else $error("sync drive");
  bus_form_a:
    assert property (device_address_bus8 == {device_address_setting_q[6:0], 1'b0})
    else $error("bus form");
  global_hit_a:
    assert property (cfg_done_q && (bus_addr == 7'h5a || bus_addr == 7'h5b) |-> addr_match)
    else $error("global missed");
  other_hit_a:
    assert property (cfg_done_q && ((!device_address_setting_q[7] &&
      bus_addr == device_address_setting_q[6:0]) || (!group_address_setting_q[7] &&
      bus_addr == group_address_setting_q[6:0])) |-> addr_match) else $error("addr missed");
  early_hit_a:
    assert property (!cfg_done_q |-> !addr_match) else $error("early match");
  dev_write_a:
    assert property (addr_wr_en && cfg_done_q && !addr_wr_group |=>
      device_address_setting_q == $past(addr_wr_data)) else $error("write lost");
endmodule

bind scd_strap_decoder scd_strap_props u_props (.sys_clk(sys_clk), .rst(rst),
  .out_level_strap_open(out_level_strap_open), .clock_phase_strap_open(clock_phase_strap_open),
  .addr_wr_en(addr_wr_en), .addr_wr_group(addr_wr_group), .addr_wr_data(addr_wr_data),
  .bus_addr(bus_addr), .setpoint_q(setpoint_q), .range_high_q(range_high_q),
  .over_voltage_fault_level(over_voltage_fault_level), .freq_khz_q(freq_khz_q),
  .phase_deg_q(phase_deg_q), .sync_drive_en_q(sync_drive_en_q),
  .device_address_setting_q(device_address_setting_q),
  .group_address_setting_q(group_address_setting_q),
  .device_address_bus8(device_address_bus8), .addr_match(addr_match), .cfg_done_q(cfg_done_q));

// File: test/scd_strap_net.sv
`timescale 1ns/1ns
module scd_strap_net (
  input wire [19:0] code,
  input wire wobble,
  output wire [3:0] ol_lvl,
  output wire ol_open,
  output wire [3:0] tr_lvl,
  output wire tr_open,
  output wire [3:0] cp_lvl,
  output wire cp_open,
  output wire [3:0] ad_lvl,
  output wire ad_open
);
  // Each five-bit field is one divider, open flag above level; a floating one reads junk.
  // Wobble models a divider reworked after power-up.
  assign ol_lvl = code[3:0] ^ {4{wobble ^ code[4]}};
  assign tr_lvl = code[8:5] ^ {4{wobble ^ code[9]}};
  assign cp_lvl = code[13:10] ^ {4{wobble ^ code[14]}};
  assign ad_lvl = code[18:15] ^ {4{wobble ^ code[19]}};
  assign ol_open = code[4];
  assign tr_open = code[9];
  assign cp_open = code[14];
  assign ad_open = code[19];
endmodule

// File: test/scd_strap_decoder_tb.sv
`timescale 1ns/1ns
module scd_strap_decoder_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] code = 20'h00000;
  logic wobble = 1'b0;
  logic [15:0] nvm [10] = '{default: 16'h0000};
  logic nvm_rng = 1'b0;
  logic [9:0] nvm_fq = 10'h000;
  logic [8:0] nvm_ph = 9'h000;
  logic nvm_prog = 1'b0;
  logic [7:0] nvm_dev = 8'h00;
  logic [7:0] nvm_grp = 8'h00;
  logic wr_en = 1'b0;
  logic wr_grp = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [6:0] bus_addr = 7'h00;
  wire [3:0] ol_lvl, tr_lvl, cp_lvl, ad_lvl;
  wire ol_open, tr_open, cp_open, ad_open, rng_q, sync_q, hit, done_q;
  wire [15:0] sp_q;
  wire [15:0] lim [9];
  wire [9:0] fq_q;
  wire [8:0] ph_q;
  wire [7:0] dev_q, grp_q, bus8;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] hv_tab [16] = '{16'habe0, 16'habe0, 16'habe0, 16'habe0, 16'habe0, 16'habe0,
    16'ha410, 16'h9c40, 16'h9470, 16'h8ca0, 16'h84d0, 16'h7d00, 16'h7530, 16'h7170,
    16'h6d60, 16'h6c20};
  logic [9:0] fq_tab [6] = '{10'h0fa, 10'h1a9, 10'h1f4, 10'h23f, 10'h28a, 10'h000};
  logic [8:0] ph_tab [3] = '{9'h000, 9'h078, 9'h0b4};
  int pm_tab [9] = '{1100, 1075, 1075, 1050, 930, 920, 950, 935, 930};

  scd_strap_net u_net (.code(code), .wobble(wobble), .ol_lvl(ol_lvl), .ol_open(ol_open),
    .tr_lvl(tr_lvl), .tr_open(tr_open), .cp_lvl(cp_lvl), .cp_open(cp_open),
    .ad_lvl(ad_lvl), .ad_open(ad_open));
  scd_strap_decoder dut (.sys_clk(sys_clk), .rst(rst),
    .out_level_strap_lvl(ol_lvl), .out_level_strap_open(ol_open),
    .out_trim_strap_lvl(tr_lvl), .out_trim_strap_open(tr_open),
    .clock_phase_strap_lvl(cp_lvl), .clock_phase_strap_open(cp_open),
    .address_strap_lvl(ad_lvl), .address_strap_open(ad_open),
    .nvm_setpoint(nvm[0]), .nvm_range_high(nvm_rng), .nvm_ov_fault(nvm[1]),
    .nvm_ov_warn(nvm[2]), .nvm_ceiling(nvm[3]), .nvm_up_margin(nvm[4]), .nvm_pg_on(nvm[5]),
    .nvm_pg_off(nvm[6]), .nvm_lo_margin(nvm[7]), .nvm_uv_warn(nvm[8]), .nvm_uv_fault(nvm[9]),
    .nvm_freq_khz(nvm_fq), .nvm_phase_deg(nvm_ph), .nvm_addr_programmed(nvm_prog),
    .nvm_dev_addr(nvm_dev), .nvm_group_addr(nvm_grp), .addr_wr_en(wr_en),
    .addr_wr_group(wr_grp), .addr_wr_data(wr_data), .bus_addr(bus_addr), .setpoint_q(sp_q),
    .range_high_q(rng_q), .over_voltage_fault_level(lim[0]), .over_voltage_warn_level(lim[1]),
    .output_ceiling(lim[2]), .upper_margin_level(lim[3]), .pgood_on_level(lim[4]),
    .pgood_off_level(lim[5]), .lower_margin_level(lim[6]), .under_voltage_warn_level(lim[7]),
    .under_voltage_fault_level(lim[8]), .freq_khz_q(fq_q), .phase_deg_q(ph_q),
    .sync_drive_en_q(sync_q), .device_address_setting_q(dev_q), .group_address_setting_q(grp_q),
    .device_address_bus8(bus8), .addr_match(hit), .cfg_done_q(done_q));

  initial forever #2 sys_clk = ~sys_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Set point in 0.125 mV units: base level plus trim, or the high column when deferring.
  function automatic logic [15:0] exp_sp(input logic [3:0] v, t, input logic topen);
    int b;
    int tr;
    b = 32'sh6720 - 32'sh640 * (int'(v) - 32'sh1);
    tr = (int'(t) < 32'sh8) ? 32'sh318 - 32'sh63 * int'(t) : 32'sh2b5 - 32'sh63 * int'(t);
    if (topen)
      tr = 32'sh0;
    if (v == 4'h0)
      return hv_tab[t];
    return 16'(b + tr);
  endfunction

  // A host write during decode must be dropped, so every boot tries one.
  task boot(input logic [3:0] vo, tr, fq, ad, input logic [3:0] opn);
    int k;
    @(posedge sys_clk);
    rst <= 1'b1;
    code <= {opn[3], ad, opn[2], fq, opn[1], tr, opn[0], vo};
    repeat (5) @(posedge sys_clk);
    #1;
    chk(dev_q, 8'h4f);
    chk(hit, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_data <= 8'h22;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    k = 0;
    while (done_q !== 1'b1 && k < 30)
    begin
      @(posedge sys_clk);
      k++;
    end
    #1;
    chk(done_q, 1'b1);
  endtask

  task wr(input logic g, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_grp <= g;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  task mt(input logic [6:0] a, input logic e);
    @(posedge sys_clk);
    bus_addr <= a;
    #1;
    chk(hit, e);
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_fail++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish;
  end

  initial
  begin
    int i;
    int j;
    logic [15:0] e;
    for (i = 0; i < 16; i++)
    begin
      boot(i[3:0], i[3:0], i[3:0], i[3:0], 4'h0);
      e = exp_sp(i[3:0], i[3:0], 1'b0);
      chk(sp_q, e);
      chk(rng_q, e > 16'h4e20);
      chk(fq_q, fq_tab[i / 3]);
      chk(ph_q, (i == 7) ? 9'h000 : ph_tab[i % 3]);
      chk(sync_q, fq_tab[i / 3] != 10'h000);
      chk(dev_q, {4'h4, ~i[3:0]});
      chk(grp_q, 8'h80);
      for (j = 0; j < 9; j++)
        chk(lim[j], 16'((32'(e) * pm_tab[j]) / 1000));
    end
    for (i = 5; i < 16; i++)
    begin
      boot(4'h0, i[3:0], 4'h0, 4'h0, 4'h0);
      chk(sp_q, hv_tab[i]);
      chk(rng_q, 1'b1);
    end
    // Open trim gives exactly 2.5 V, the top of the low range; open address keeps default.
    boot(4'h5, 4'h3, 4'h0, 4'h0, 4'ha);
    chk(sp_q, exp_sp(4'h5, 4'h3, 1'b1));
    chk(rng_q, 1'b0);
    chk(dev_q, 8'h4f);
    @(posedge sys_clk);
    for (i = 0; i < 10; i++)
      nvm[i] <= 16'h2ee0 + 16'h0101 * i[15:0];
    nvm_rng <= 1'b1;
    nvm_fq <= 10'h15e;
    nvm_ph <= 9'h05a;
    nvm_prog <= 1'b1;
    nvm_dev <= 8'h60;
    nvm_grp <= 8'h61;
    boot(4'hd, 4'hf, 4'h0, 4'ha, 4'h4);
    chk(sp_q, exp_sp(4'hd, 4'hf, 1'b0));
    chk(fq_q, 10'h15e);
    chk(ph_q, 9'h05a);
    chk(dev_q, 8'h65);
    boot(4'h0, 4'h0, 4'h0, 4'h0, 4'hf);
    chk(sp_q, 16'h2ee0);
    chk(rng_q, 1'b1);
    chk(lim[0], nvm[1]);
    for (j = 1; j < 9; j++)
      chk(lim[j], nvm[j + 1]);
    chk(dev_q, 8'h60);
    chk(grp_q, 8'h61);
    chk(bus8, 8'hc0);
    mt(7'h60, 1'b1);
    mt(7'h5a, 1'b1);
    mt(7'h5b, 1'b1);
    mt(7'h62, 1'b0);
    wr(1'b0, 8'h80);
    #1;
    chk(dev_q, 8'h80);
    mt(7'h60, 1'b0);
    mt(7'h61, 1'b1);
    mt(7'h5b, 1'b1);
    wr(1'b1, 8'h80);
    wr(1'b0, 8'h4e);
    mt(7'h61, 1'b0);
    mt(7'h4e, 1'b1);
    chk(bus8, 8'h9c);
    boot(4'h2, 4'h0, 4'h4, 4'h0, 4'h0);
    @(posedge sys_clk);
    wobble <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    chk(sp_q, exp_sp(4'h2, 4'h0, 1'b0));
    chk(fq_q, fq_tab[1]);
    boot(4'h2, 4'h0, 4'h4, 4'h0, 4'h0);
    chk(sp_q, exp_sp(4'hd, 4'hf, 1'b0));
    chk(fq_q, fq_tab[3]);
    tally_and_finish;
  end
endmodule
